// file: hw/pwel_pkg.sv
package pwel_pkg;
	// Register byte offsets
	localparam logic [7:0] PWEL_CTRL1_OFS = 8'h00;
	localparam logic [7:0] PWEL_CTRL2_OFS = 8'h04;
	localparam logic [7:0] PWEL_STAT_OFS = 8'h08;
	localparam logic [7:0] PWEL_MASK_OFS = 8'h0C;
	localparam logic [7:0] PWEL_LEVEL_OFS = 8'h10;
	// power_control_reg_one fields
	localparam int PWEL_C1_EV1_MODE = 0;
	localparam int PWEL_C1_EV2_MODE = 2;
	localparam int PWEL_C1_EV1_ROUTE = 4;
	localparam int PWEL_C1_EV2_ROUTE = 6;
	localparam int PWEL_C1_OFF_LEVEL = 8;
	localparam int PWEL_C1_RING_EN = 9;
	localparam int PWEL_C1_PULSE_EN = 10;
	localparam int PWEL_C1_ON_CLR = 11;
	localparam int PWEL_C1_OFF_CLR = 12;
	// power_control_reg_two fields
	localparam int PWEL_C2_PULSE_SEL = 0;
	// Status and mask bit positions
	localparam int PWEL_ST_EV1 = 0;
	localparam int PWEL_ST_EV2 = 1;
	localparam int PWEL_ST_RING = 2;
	localparam int PWEL_ST_PULSE = 3;
	localparam int PWEL_ST_SW_ON = 4;
	localparam int PWEL_ST_SW_OFF = 5;
	localparam int PWEL_ST_W = 6;
	// Reset values
	localparam logic [31:0] PWEL_CTRL1_RST = 32'h0000_0000;
	localparam logic [31:0] PWEL_CTRL2_RST = 32'h0000_0000;
	localparam logic [31:0] PWEL_MASK_RST = 32'h0000_0000;
	// Event input sensitivity
	typedef enum logic [1:0] {
		PWEL_LOW = 2'b00,
		PWEL_HIGH = 2'b01,
		PWEL_RISE = 2'b10,
		PWEL_FALL = 2'b11
	} pwel_sense_type;
	// Event routing
	typedef enum logic [1:0] {
		PWEL_TO_NONE = 2'b00,
		PWEL_TO_OFF = 2'b01,
		PWEL_TO_SCI = 2'b10,
		PWEL_TO_ON = 2'b11
	} pwel_route_type;
	// Debounce timing
	localparam int PWEL_CLK_HZ = 25_000_000;
	localparam int PWEL_DEBOUNCE_MS = 16;
	localparam int PWEL_DEBOUNCE_CYC = PWEL_CLK_HZ / 1000 * PWEL_DEBOUNCE_MS;
	localparam int PWEL_DB_W = 20;
endpackage

// file: hw/pwel_debounce.sv
`timescale 1ns/1ns
// Accepts a new switch level only after it held steady for debounce_cyc cycles
module pwel_debounce #(
	parameter int DEBOUNCE_CYC = pwel_pkg::PWEL_DEBOUNCE_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic raw_i,
	output logic stable_o,
	output logic rise_o,
	output logic fall_o
);
	import pwel_pkg::*;

	logic [PWEL_DB_W-1:0] cnt_reg;
	logic stable_reg;
	logic rise_reg;
	logic fall_reg;
	wire differ = raw_i != stable_reg;
	wire expired = cnt_reg >= PWEL_DB_W'(DEBOUNCE_CYC - 1);

	// Counter restarts on every bounce; short glitches never reach the output
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			stable_reg <= 1'b1;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end else begin
			rise_reg <= differ && expired && raw_i;
			fall_reg <= differ && expired && !raw_i;
			if (!differ) begin
				cnt_reg <= '0;
			end else if (expired) begin
				cnt_reg <= '0;
				stable_reg <= raw_i;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end
	end

	assign stable_o = stable_reg;
	assign rise_o = rise_reg;
	assign fall_o = fall_reg;

	AST_DB_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$changed(stable_reg) |-> $past(raw_i, 1) == stable_reg && $past(differ, 2))
		else $error("Debounced level changed without a held input");
endmodule // pwel_debounce

// file: hw/pwel_core.sv
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module pwel_core #(
	parameter int DEBOUNCE_CYC = pwel_pkg::PWEL_DEBOUNCE_CYC
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hsel_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic power_event_in1_i,
	input wire logic power_event_in2_i,
	input wire logic modem_call_line1_n_i,
	input wire logic modem_call_line2_n_i,
	input wire logic ring_pin_a_n_i,
	input wire logic ring_pin_b_n_i,
	input wire logic power_switch_n_i,
	output logic supply_on_output_n_o,
	output logic supply_on_output_oe_o,
	output logic power_off_req_n_o,
	output logic system_control_interrupt_o,
	output logic irq_o
);
	import pwel_pkg::*;

	// Registers
	logic [31:0] ctrl1_reg;
	logic [31:0] ctrl2_reg;
	logic [PWEL_ST_W-1:0] stat_reg;
	logic [PWEL_ST_W-1:0] mask_reg;
	logic [31:0] hrdata_reg;
	logic on_reg;
	logic off_reg;
	logic off_pulse_reg;
	logic [1:0] ev_prev_reg;
	logic [1:0] call_prev_reg;
	logic pulse_prev_reg;

	// AHB address phase capture
	logic wr_pend_reg;
	logic [7:0] addr_reg;
	wire ahb_go = hsel_i && hready_i && htrans_i[1];
	wire ahb_wr = ahb_go && hwrite_i;
	wire ahb_rd = ahb_go && !hwrite_i;
	wire [7:0] ahb_ofs = haddr_i[7:0];

	// Write strobes decoded in the data phase
	wire wr_c1 = wr_pend_reg && addr_reg == PWEL_CTRL1_OFS;
	wire wr_c2 = wr_pend_reg && addr_reg == PWEL_CTRL2_OFS;
	wire wr_st = wr_pend_reg && addr_reg == PWEL_STAT_OFS;
	wire wr_mk = wr_pend_reg && addr_reg == PWEL_MASK_OFS;

	// Debounced power switch
	logic sw_level;
	logic sw_rise;
	logic sw_fall;
	pwel_debounce #(
		.DEBOUNCE_CYC(DEBOUNCE_CYC)
	) u_debounce (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.raw_i(power_switch_n_i),
		.stable_o(sw_level),
		.rise_o(sw_rise),
		.fall_o(sw_fall)
	);
	// Momentary switch pressed low: first press switches on, next switches off
	wire sw_on_ev = sw_fall && !on_reg;
	wire sw_off_ev = sw_fall && on_reg;

	// Power event sensing, one lane per input
	// Level senses re-flag every cycle the level stands, so a clear only sticks once it drops
	wire [1:0] ev_raw = {power_event_in2_i, power_event_in1_i};
	logic [1:0] ev_det;
	logic [1:0] ev_to_off;
	logic [1:0] ev_to_sci;
	logic [1:0] ev_to_on;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ev
			wire [1:0] sense = ctrl1_reg[PWEL_C1_EV1_MODE + 2*gi +: 2];
			wire [1:0] route = ctrl1_reg[PWEL_C1_EV1_ROUTE + 2*gi +: 2];
			assign ev_det[gi] = (sense == PWEL_LOW) ? !ev_raw[gi] :
				(sense == PWEL_HIGH) ? ev_raw[gi] :
				(sense == PWEL_RISE) ? ev_raw[gi] && !ev_prev_reg[gi] :
				!ev_raw[gi] && ev_prev_reg[gi];
			assign ev_to_off[gi] = ev_det[gi] && route == PWEL_TO_OFF;
			assign ev_to_sci[gi] = ev_det[gi] && route == PWEL_TO_SCI;
			assign ev_to_on[gi] = ev_det[gi] && route == PWEL_TO_ON;
		end
	endgenerate

	// Modem call line falling edges when ring wake is on
	wire [1:0] call_now = {modem_call_line2_n_i, modem_call_line1_n_i};
	wire call_fall = ctrl1_reg[PWEL_C1_RING_EN] && |(call_prev_reg & ~call_now);

	// Ring pulse from the selected pin; each low-going edge counts, so a train wakes too
	wire pulse_now = ctrl2_reg[PWEL_C2_PULSE_SEL] ? ring_pin_b_n_i : ring_pin_a_n_i;
	wire pulse_fall = ctrl1_reg[PWEL_C1_PULSE_EN] && pulse_prev_reg && !pulse_now;

	// Wake and off requests
	wire wake = sw_on_ev || call_fall || pulse_fall || |ev_to_on;
	wire off_ev = sw_off_ev || |ev_to_off;
	wire off_level = ctrl1_reg[PWEL_C1_OFF_LEVEL];
	wire on_clr = wr_c1 && hwdata_i[PWEL_C1_ON_CLR];
	wire off_clr = wr_c1 && hwdata_i[PWEL_C1_OFF_CLR];
	wire [PWEL_ST_W-1:0] st_set = {sw_off_ev, sw_on_ev, pulse_fall, call_fall, ev_det};

	// Input history for edge detection
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ev_prev_reg <= 2'b00;
			call_prev_reg <= 2'b11;
			pulse_prev_reg <= 1'b1;
		end else begin
			ev_prev_reg <= ev_raw;
			call_prev_reg <= call_now;
			pulse_prev_reg <= pulse_now;
		end
	end

	// Power-on latch: set wins over software clear
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			on_reg <= 1'b0;
		end else if (wake) begin
			on_reg <= 1'b1;
		end else if (on_clr || sw_off_ev) begin
			on_reg <= 1'b0;
		end
	end

	// Power-off request, held level or a pulse that lasts as long as the off event
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			off_reg <= 1'b0;
			off_pulse_reg <= 1'b0;
		end else begin
			off_pulse_reg <= off_ev;
			if (off_ev) begin
				off_reg <= 1'b1;
			end else if (off_clr || !off_level) begin
				off_reg <= 1'b0;
			end
		end
	end

	// Open-drain supply control: drive low only while power is requested
	assign supply_on_output_n_o = 1'b0;
	assign supply_on_output_oe_o = on_reg;
	assign power_off_req_n_o = !(off_level ? off_reg : off_pulse_reg);
	assign system_control_interrupt_o = |ev_to_sci;

	// Bus slave state and register writes
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= 8'h00;
			ctrl1_reg <= PWEL_CTRL1_RST;
			ctrl2_reg <= PWEL_CTRL2_RST;
			mask_reg <= PWEL_MASK_RST[PWEL_ST_W-1:0];
		end else begin
			wr_pend_reg <= ahb_wr;
			if (ahb_go) begin
				addr_reg <= ahb_ofs;
			end
			if (wr_c1) begin
				ctrl1_reg <= {19'h0_0000, 2'b00, hwdata_i[10:0]};
			end
			if (wr_c2) begin
				ctrl2_reg <= {31'h0000_0000, hwdata_i[PWEL_C2_PULSE_SEL]};
			end
			if (wr_mk) begin
				mask_reg <= hwdata_i[PWEL_ST_W-1:0];
			end
		end
	end

	// Sticky status: a new event beats a write-one clear in the same cycle
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			stat_reg <= '0;
		end else begin
			stat_reg <= (stat_reg & ~(wr_st ? hwdata_i[PWEL_ST_W-1:0] : '0)) | st_set;
		end
	end

	// Read data captured in the address phase; unmapped offsets read zero
	// Status read this way is one cycle old, which software polling cannot notice
	wire [31:0] rd_mux = (ahb_ofs == PWEL_CTRL1_OFS) ? ctrl1_reg :
		(ahb_ofs == PWEL_CTRL2_OFS) ? ctrl2_reg :
		(ahb_ofs == PWEL_STAT_OFS) ? {26'h000_0000, stat_reg} :
		(ahb_ofs == PWEL_MASK_OFS) ? {26'h000_0000, mask_reg} :
		(ahb_ofs == PWEL_LEVEL_OFS) ? {29'h0000_0000, sw_level, off_reg, on_reg} :
		32'h0000_0000;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (ahb_rd) begin
			hrdata_reg <= rd_mux;
		end
	end

	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign irq_o = |(stat_reg & mask_reg);

	// Checks
	AST_RING_WAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctrl1_reg[PWEL_C1_RING_EN] && $fell(modem_call_line1_n_i) |=> on_reg)
		else $error("Modem call edge did not raise power-on");
	AST_PULSE_WAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		pulse_fall |=> supply_on_output_oe_o)
		else $error("Ring pulse did not raise power-on");
	AST_PULSE_SEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctrl1_reg[PWEL_C1_PULSE_EN] && ctrl2_reg[PWEL_C2_PULSE_SEL] &&
		$past(ctrl2_reg[PWEL_C2_PULSE_SEL]) && $fell(ring_pin_b_n_i) |=> on_reg)
		else $error("Ring pulse on the selected pin did not raise power-on");
	AST_OFF_NOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sw_off_ev |=> !power_off_req_n_o)
		else $error("Switch-off did not request power-off next cycle");
	AST_OFF_PULSE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!off_level && $past(!off_level) && !power_off_req_n_o && !$past(off_ev) |-> 1'b0)
		else $error("Pulse mode power-off request outlived its event");
	AST_OFF_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		off_level && !power_off_req_n_o && !off_clr ##1 off_level |-> !power_off_req_n_o)
		else $error("Level mode power-off request dropped");
	AST_EV_ROUTE_ON: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ev_to_on[0] |=> on_reg)
		else $error("Routed power event did not raise power-on");
	AST_EV_LOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		g_ev[0].sense == PWEL_LOW && !power_event_in1_i |=> stat_reg[PWEL_ST_EV1])
		else $error("Low-sensed event not flagged");
	AST_WAKE_OR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(on_reg) |-> $past(wake))
		else $error("Power-on rose with no wake source");

	// Event sensing and routing
	AST_EV_HIGH: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		g_ev[1].sense == PWEL_HIGH && power_event_in2_i |=> stat_reg[PWEL_ST_EV2])
		else $error("High-sensed event not flagged");
	AST_EV_RISE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		g_ev[1].sense == PWEL_RISE && $rose(power_event_in2_i) |=> stat_reg[PWEL_ST_EV2])
		else $error("Rising event not flagged");
	AST_EV_FALL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		g_ev[0].sense == PWEL_FALL && $fell(power_event_in1_i) |=> stat_reg[PWEL_ST_EV1])
		else $error("Falling event not flagged");
	AST_SCI_ROUTE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ev_det[0] && g_ev[0].route == PWEL_TO_SCI |-> system_control_interrupt_o)
		else $error("Event routed to control interrupt not signalled");
	AST_EV_ROUTE_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ev_to_off[1] |=> !power_off_req_n_o)
		else $error("Event routed to power-off did not request it");

	// Power-on and power-off outputs
	AST_SW_OFF_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sw_off_ev && !wake |=> !on_reg)
		else $error("Switch-off left power-on asserted");
	AST_OFF_LEVEL_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		off_level && off_clr && !off_ev |=> power_off_req_n_o)
		else $error("Held power-off request survived its clear");
	AST_ON_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		on_reg && !on_clr && !sw_off_ev |=> on_reg)
		else $error("Power-on dropped without a clear");

	// Ring inputs
	AST_RING_WAKE2: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctrl1_reg[PWEL_C1_RING_EN] && $fell(modem_call_line2_n_i) |=> on_reg)
		else $error("Second modem call edge did not raise power-on");
	AST_PIN_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctrl1_reg[PWEL_C1_PULSE_EN] && !ctrl2_reg[PWEL_C2_PULSE_SEL] &&
		!$past(ctrl2_reg[PWEL_C2_PULSE_SEL]) && $fell(ring_pin_a_n_i) |=> on_reg)
		else $error("Ring pulse on the first pin did not raise power-on");

	// Switch and status
	AST_SW_FALL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sw_fall |-> !sw_level)
		else $error("Switch press edge without a low level");
	AST_SW_RISE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sw_rise |-> sw_level)
		else $error("Switch release edge without a high level");
	AST_SW_WAKE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		sw_on_ev |=> on_reg)
		else $error("Switch-on did not raise power-on");
	AST_STAT_STICKY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		stat_reg[PWEL_ST_SW_OFF] && !(wr_st && hwdata_i[PWEL_ST_SW_OFF]) |=>
		stat_reg[PWEL_ST_SW_OFF])
		else $error("Status bit dropped without a write-one clear");
endmodule // pwel_core

// file: verif/pwel_supply_model.sv
`timescale 1ns/1ns
// Main supply and chipset side of the power pins
module pwel_supply_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic on_n_i,
	input wire logic on_oe_i,
	input wire logic off_req_n_i,
	output logic powered_o,
	output int off_cnt_o
);
	logic off_d_reg;
	// Pin has a pull-up, so power is on only while the pin is actively sunk low
	assign powered_o = on_oe_i & ~on_n_i;
	// Count each fall of the off request; a one-cycle pulse is caught as well as a level
	always_ff @(posedge ref_clk_i) begin
		off_d_reg <= off_req_n_i;
		if (rst_i) begin
			off_cnt_o <= 0;
		end else if (off_d_reg & ~off_req_n_i) begin
			off_cnt_o <= off_cnt_o + 1;
		end
	end
endmodule // pwel_supply_model

// file: verif/power_wake_event_logic_tb_top.sv
`timescale 1ns/1ns
module power_wake_event_logic_tb_top;
	import pwel_pkg::*;
	localparam int DB = 8;
	logic ref_clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic hsel = 1'h0;
	logic ev1 = 1'h0;
	logic ev2 = 1'h0;
	logic ml1 = 1'h1;
	logic ml2 = 1'h1;
	logic rpa = 1'h1;
	logic rpb = 1'h1;
	logic sw = 1'h1;
	logic hready, hresp, on_n, on_oe, off_n, system_control_interrupt, irq, powered;
	int off_cnt;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	// Short debounce keeps the switch scenarios brief
	pwel_core #(.DEBOUNCE_CYC(DB)) uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hsel_i(hsel), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .power_event_in1_i(ev1),
		.power_event_in2_i(ev2), .modem_call_line1_n_i(ml1), .modem_call_line2_n_i(ml2),
		.ring_pin_a_n_i(rpa), .ring_pin_b_n_i(rpb), .power_switch_n_i(sw),
		.supply_on_output_n_o(on_n), .supply_on_output_oe_o(on_oe),
		.power_off_req_n_o(off_n), .system_control_interrupt_o(system_control_interrupt), .irq_o(irq));
	pwel_supply_model supply (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .on_n_i(on_n),
		.on_oe_i(on_oe), .off_req_n_i(off_n), .powered_o(powered), .off_cnt_o(off_cnt));
	initial forever #20 ref_clk_i = ~ref_clk_i;
	// Cut a hang short well past the expected run length
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors = n_errors + 1;
			report_and_stop();
		end
	end
	task report_and_stop;
		if (n_errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks = checks + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// One single AHB transfer; waits on hready in both phases
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk_i);
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'h1;
		do @(posedge ref_clk_i); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk_i); while (hready !== 1'h1);
		r = hrdata;
		hsel <= 1'h0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(a, 1'h1, d, r);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		xfer(a, 1'h0, 32'h0000_0000, r);
		chk(r, e);
	endtask
	task press;
		@(posedge ref_clk_i);
		sw <= 1'h0;
		cyc(DB + 4);
		sw <= 1'h1;
		cyc(DB + 4);
	endtask
	task t_reset;
		rd_chk(PWEL_CTRL1_OFS, PWEL_CTRL1_RST);
		rd_chk(PWEL_CTRL2_OFS, PWEL_CTRL2_RST);
		rd_chk(PWEL_MASK_OFS, PWEL_MASK_RST);
		wr(8'h40, 32'hFFFF_FFFF);
		rd_chk(8'h40, 32'h0000_0000);
		chk(hresp, 1'h0);
		chk(hready, 1'h1);
		chk(on_oe, 1'h0);
		chk(off_n, 1'h1);
		chk(irq, 1'h0);
	endtask
	// Every sensitivity on input one, routed to the control interrupt
	task t_sense;
		logic [1:0] m;
		logic seen;
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			@(posedge ref_clk_i);
			ev1 <= ~^m;
			wr(PWEL_CTRL1_OFS, {26'h000_0000, 2'h2, 2'h1, m}); // Input two high-sensed, idle
			wr(PWEL_STAT_OFS, 32'h0000_003F);
			rd_chk(PWEL_STAT_OFS, 32'h0000_0000);
			@(posedge ref_clk_i);
			ev1 <= ^m;
			seen = 1'h0;
			repeat (4) begin
				@(posedge ref_clk_i);
				seen = seen | system_control_interrupt;
			end
			chk(seen, 1'h1);
			rd_chk(PWEL_STAT_OFS, 32'h0000_0001);
		end
	endtask
	task t_route;
		int n;
		wr(PWEL_CTRL1_OFS, 32'h0000_00C4);
		@(posedge ref_clk_i);
		ev2 <= 1'h1;
		cyc(4);
		chk(on_oe, 1'h1);
		chk(powered, 1'h1);
		// Drop the wake source first: a standing wake beats the clear
		@(posedge ref_clk_i);
		ev2 <= 1'h0;
		wr(PWEL_CTRL1_OFS, 32'h0000_0800);
		cyc(2);
		chk(on_oe, 1'h0);
		wr(PWEL_CTRL1_OFS, 32'h0000_0048);
		n = off_cnt;
		@(posedge ref_clk_i);
		ev2 <= 1'h1;
		cyc(4);
		chk(off_cnt - n, 1);
		chk(off_n, 1'h1);
		@(posedge ref_clk_i);
		ev2 <= 1'h0;
		wr(PWEL_CTRL1_OFS, 32'h0000_0148);
		@(posedge ref_clk_i);
		ev2 <= 1'h1;
		cyc(8);
		chk(off_n, 1'h0);
		rd_chk(PWEL_LEVEL_OFS, 32'h0000_0006);
		wr(PWEL_CTRL1_OFS, 32'h0000_1148);
		cyc(2);
		chk(off_n, 1'h1);
	endtask
	task t_ring;
		wr(PWEL_CTRL1_OFS, 32'h0000_0000);
		@(posedge ref_clk_i);
		ml1 <= 1'h0;
		cyc(4);
		chk(on_oe, 1'h0);
		ml1 <= 1'h1;
		wr(PWEL_CTRL1_OFS, 32'h0000_0200);
		@(posedge ref_clk_i);
		ml2 <= 1'h0;
		cyc(4);
		chk(on_oe, 1'h1);
		ml2 <= 1'h1;
		wr(PWEL_CTRL1_OFS, 32'h0000_0800);
		wr(PWEL_CTRL2_OFS, 32'h0000_0001);
		rd_chk(PWEL_CTRL2_OFS, 32'h0000_0001);
		wr(PWEL_CTRL1_OFS, 32'h0000_0400);
		chk(on_oe, 1'h0);
		@(posedge ref_clk_i);
		rpa <= 1'h0;
		cyc(2);
		rpa <= 1'h1;
		cyc(4);
		chk(on_oe, 1'h0);
		rpb <= 1'h0;
		cyc(2);
		rpb <= 1'h1;
		cyc(4);
		chk(on_oe, 1'h1);
		wr(PWEL_CTRL1_OFS, 32'h0000_0C00);
		wr(PWEL_CTRL2_OFS, 32'h0000_0000);
		chk(on_oe, 1'h0);
		@(posedge ref_clk_i);
		rpa <= 1'h0;
		cyc(2);
		rpa <= 1'h1;
		cyc(4);
		chk(on_oe, 1'h1);
		wr(PWEL_CTRL1_OFS, 32'h0000_0800);
	endtask
	task t_switch;
		int n;
		wr(PWEL_CTRL1_OFS, 32'h0000_0001);
		wr(PWEL_STAT_OFS, 32'h0000_003F);
		@(posedge ref_clk_i);
		sw <= 1'h0;
		cyc(DB - 3);
		sw <= 1'h1;
		cyc(DB + 6);
		chk(on_oe, 1'h0);
		press();
		chk(on_oe, 1'h1);
		rd_chk(PWEL_LEVEL_OFS, 32'h0000_0005);
		n = off_cnt;
		press();
		chk(on_oe, 1'h0);
		chk(off_cnt - n, 1);
		rd_chk(PWEL_STAT_OFS, 32'h0000_0030);
		rd_chk(PWEL_LEVEL_OFS, 32'h0000_0004);
	endtask
	task t_irq;
		wr(PWEL_MASK_OFS, 32'h0000_0020);
		rd_chk(PWEL_MASK_OFS, 32'h0000_0020);
		chk(irq, 1'h1);
		wr(PWEL_STAT_OFS, 32'h0000_0020);
		rd_chk(PWEL_STAT_OFS, 32'h0000_0010);
		chk(irq, 1'h0);
		wr(PWEL_MASK_OFS, 32'h0000_0010);
		cyc(2);
		chk(irq, 1'h1);
	endtask
	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'h0;
		t_reset();
		t_sense();
		t_route();
		t_ring();
		t_switch();
		t_irq();
		report_and_stop();
	end
endmodule // power_wake_event_logic_tb_top
